/* File: udw_pkg.sv */
// Purpose: shared constants and types for the up/down wiper host controller
// Assumes: 100 MHz system clock
// Notes: chip select level is encoded, the board turns it into pin voltages
package udw_pkg;

  localparam int unsigned UDW_CLK_MHZ = 100;
  // nonvolatile write time, microseconds; a plain default, board may differ
  localparam int unsigned UDW_NV_WRITE_TIME_US = 5000;
  localparam int unsigned UDW_NV_WRITE_CYC = UDW_NV_WRITE_TIME_US * UDW_CLK_MHZ;
  // pin setup and hold, nanoseconds
  localparam int unsigned UDW_PIN_SETUP_NS = 500;
  localparam int unsigned UDW_PIN_SETUP_CYC = (UDW_PIN_SETUP_NS * UDW_CLK_MHZ + 999) / 1000;
  localparam int unsigned UDW_CODE_W = 6;
  localparam logic [5:0] UDW_CODE_MIN = 6'h00;
  localparam logic [5:0] UDW_CODE_MAX = 6'h3F;

  // chip select drive level
  typedef enum logic [1:0]
  {
    UDW_CS_LOW = 2'b00,
    UDW_CS_HIGH = 2'b01,
    UDW_CS_HV = 2'b10
  } udw_cs_e;

  // host commands
  typedef enum logic [3:0]
  {
    UDW_OP_INC = 4'b0000,
    UDW_OP_DEC = 4'b0001,
    UDW_OP_INC_STORE = 4'b0010,
    UDW_OP_DEC_STORE = 4'b0011,
    UDW_OP_STORE = 4'b0100,
    UDW_OP_HV_INC_UNLOCK = 4'b0101,
    UDW_OP_HV_INC_LOCK = 4'b0110,
    UDW_OP_HV_DEC_UNLOCK = 4'b0111,
    UDW_OP_HV_DEC_LOCK = 4'b1000,
    UDW_OP_HV_STORE_UNLOCK = 4'b1001,
    UDW_OP_HV_STORE_LOCK = 4'b1010
  } udw_op_e;

  typedef struct packed
  {
    udw_op_e op;
    logic [5:0] steps;
  } udw_cmd_s;

  typedef struct packed
  {
    udw_cs_e cs_level;
    logic step_dir;
  } udw_pins_s;

endpackage : udw_pkg

/* File: udw_timer.sv */
// Purpose: loadable down counter for pin timing and the write wait
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ns
`default_nettype none
module udw_timer #(
  parameter int unsigned WIDTH = 20
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // control
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  // status
  output logic o_done
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      count_q <= '0;
    else if (i_ce)
    begin
      if (i_load)
        count_q <= i_value;
      else if (count_q != '0)
        count_q <= count_q - 1'b1;
    end
  end

  assign o_done = (count_q == '0);

endmodule : udw_timer
`default_nettype wire

/* File: udw_host.sv */
// Purpose: host controller driving chip select and step pin of an up/down wiper
// Assumes: chip select level and step pin are buffered to the device pins by the board
// Notes: tracks the wiper code and lock flag as the device should hold them
//
// Operation
// R1: step pin low before chip select enters the high-voltage level makes each later rising edge step toward B.
// R2: in the high-voltage decrement form, step pin high at exit stores the wiper and sets the lock.
// R3: after chip select leaves the high-voltage level no command is issued until the write time has passed.
// R4: the tracked code never steps below zero.
// R5: step pin held static through a high-voltage pulse stores the wiper and clears the lock.
// R6: starting high, the step pin goes low inside the high-voltage pulse, storing and setting the lock without a step.
// R7: chip select returns to normal high promptly after entering the high-voltage level.
// R8: six high-voltage command forms exist: step up or down with lock set or cleared, and store with lock set or cleared.
// R9: code zero puts the wiper at terminal B and the top code at terminal A, one resistor step per code.
// R10: the tracked code never steps above its top value.
// R11: step pin high before chip select enters the high-voltage level makes each later rising edge step toward A.
// R12: high-voltage increment exits high to unlock or low to lock; high-voltage decrement exits low to unlock.
// R13: a normal-level command ending with the step pin high stores the wiper into nonvolatile memory.
// R14: the wiper code is six bits plus one lock flag, updated in the stored copy only after the write completes.
// R15: a busy indication covers the full write time after any storing command and blocks new commands.
`timescale 1ns/1ns
`default_nettype none
module udw_host
  import udw_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYC = UDW_NV_WRITE_CYC,
  parameter int unsigned SETUP_CYC = UDW_PIN_SETUP_CYC
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // command port
  input wire logic i_cmd_valid,
  input wire udw_cmd_s i_cmd,
  output logic o_cmd_ready,
  // device pins
  output udw_pins_s o_pins,
  // status
  output logic o_busy,
  output logic o_write_busy,
  output logic [UDW_CODE_W-1:0] o_wiper_code,
  output logic [UDW_CODE_W-1:0] o_stored_code,
  output logic o_lock
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SETDIR = 3'b001,
    ST_SELECT = 3'b010,
    ST_PULSE_HI = 3'b011,
    ST_PULSE_LO = 3'b100,
    ST_EXITDIR = 3'b101,
    ST_DESELECT = 3'b110,
    ST_WRITE = 3'b111
  } udw_st_e;

  localparam int TW = 32;

  udw_st_e state_q;
  udw_cmd_s cmd_q;
  logic [5:0] left_q;
  logic [5:0] code_q;
  logic [5:0] stored_q;
  logic lock_q;
  logic pend_lock_q;
  logic step_q;
  udw_cs_e cs_q;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;

  // command decode
  logic is_hv;
  logic is_up;
  logic is_step;
  logic exit_high;
  logic stores;
  logic lock_val;
  logic init_dir;

  always_comb
  begin
    is_hv = 1'b1;
    is_up = 1'b0;
    is_step = 1'b1;
    exit_high = 1'b0;
    stores = 1'b1;
    lock_val = lock_q;
    init_dir = 1'b0;
    case (cmd_q.op)
      UDW_OP_INC:
      begin
        is_hv = 1'b0; is_up = 1'b1; init_dir = 1'b1; stores = 1'b0; exit_high = 1'b0;
      end
      UDW_OP_DEC:
      begin
        is_hv = 1'b0; stores = 1'b0; exit_high = 1'b0;
      end
      UDW_OP_INC_STORE:
      begin
        is_hv = 1'b0; is_up = 1'b1; init_dir = 1'b1; exit_high = 1'b1; // [R13]
      end
      UDW_OP_DEC_STORE:
      begin
        is_hv = 1'b0; exit_high = 1'b1; // [R13]
      end
      UDW_OP_STORE:
      begin
        is_hv = 1'b0; is_step = 1'b0; init_dir = 1'b1; exit_high = 1'b1; // [R13]
      end
      UDW_OP_HV_INC_UNLOCK:
      begin
        is_up = 1'b1; init_dir = 1'b1; exit_high = 1'b1; lock_val = 1'b0; // [R11] [R12]
      end
      UDW_OP_HV_INC_LOCK:
      begin
        is_up = 1'b1; init_dir = 1'b1; exit_high = 1'b0; lock_val = 1'b1; // [R11] [R12]
      end
      UDW_OP_HV_DEC_UNLOCK:
      begin
        exit_high = 1'b0; lock_val = 1'b0; // [R1] [R12]
      end
      UDW_OP_HV_DEC_LOCK:
      begin
        exit_high = 1'b1; lock_val = 1'b1; // [R1] [R2]
      end
      UDW_OP_HV_STORE_UNLOCK:
      begin
        is_step = 1'b0; exit_high = 1'b0; lock_val = 1'b0; // [R5]
      end
      UDW_OP_HV_STORE_LOCK:
      begin
        is_step = 1'b0; init_dir = 1'b1; exit_high = 1'b0; lock_val = 1'b1; // [R6]
      end
      default:
      begin
        is_hv = 1'b0; is_step = 1'b0; stores = 1'b0;
      end
    endcase
  end

  // the [R8] decode above covers the six high-voltage forms and five normal ones; undefined codes neither step nor store
  assign o_cmd_ready = (state_q == ST_IDLE); // [R15]

  // sequencer
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      left_q <= 6'h00;
      step_q <= 1'b0;
      cs_q <= UDW_CS_HIGH;
    end
    else if (i_ce)
    begin
      case (state_q)
        ST_IDLE:
          if (i_cmd_valid)
          begin
            cmd_q <= i_cmd;
            left_q <= i_cmd.steps;
            state_q <= ST_SETDIR;
          end
        ST_SETDIR:
        begin
          step_q <= init_dir; // [R1] [R11]
          if (tmr_done)
            state_q <= ST_SELECT;
        end
        ST_SELECT:
          if (tmr_done)
          begin
            cs_q <= is_hv ? UDW_CS_HV : UDW_CS_LOW;
            // pin stays static for the store-and-unlock pulse [R5]
            // a decrement that must exit high makes one rising edge even with no steps asked [R2]
            state_q <= (is_step && (left_q != 6'h00 || (!is_up && exit_high))) ? ST_PULSE_HI : ST_EXITDIR;
          end
        ST_PULSE_HI:
          if (tmr_done)
          begin
            step_q <= 1'b1;
            left_q <= (left_q != 6'h00) ? left_q - 6'h01 : left_q;
            state_q <= ST_PULSE_LO;
          end
          else
            step_q <= 1'b0; // low before every rise, also for forms that start high [R11]
        ST_PULSE_LO:
          // pin stays high after the last rise, so a high exit adds no extra edge
          if (tmr_done)
            state_q <= (left_q != 6'h00) ? ST_PULSE_HI : ST_EXITDIR;
        ST_EXITDIR:
        begin
          if (cmd_q.op != UDW_OP_HV_STORE_UNLOCK)
            step_q <= exit_high; // [R2] [R6] [R12]
          if (tmr_done)
            state_q <= ST_DESELECT;
        end
        ST_DESELECT:
        begin
          // exit as soon as setup allows, no idle time at high voltage [R7]
          cs_q <= UDW_CS_HIGH;
          state_q <= (stores && (is_hv || exit_high)) ? ST_WRITE : ST_IDLE;
        end
        ST_WRITE:
          if (tmr_done)
            state_q <= ST_IDLE; // [R3] [R15]
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // one timer serves pin setup and the write wait
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val = TW'(SETUP_CYC);
    case (state_q)
      ST_IDLE:
        tmr_load = i_cmd_valid;
      ST_SELECT, ST_PULSE_HI, ST_PULSE_LO:
        tmr_load = tmr_done;
      ST_EXITDIR:
        tmr_load = 1'b0;
      ST_DESELECT:
      begin
        tmr_load = 1'b1;
        tmr_val = TW'(NV_WRITE_CYC); // [R3]
      end
      default:
        tmr_load = 1'b0;
    endcase
  end

  udw_timer #(
    .WIDTH(TW)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_load(tmr_load),
    .i_value(tmr_val),
    .o_done(tmr_done)
  );

  // wiper tracking: code 0 is terminal B, top code terminal A [R9]
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      code_q <= UDW_CODE_MIN;
    else if (i_ce && state_q == ST_PULSE_HI && tmr_done)
    begin
      if (is_up && code_q != UDW_CODE_MAX)
        code_q <= code_q + 6'h01; // [R10]
      else if (!is_up && code_q != UDW_CODE_MIN)
        code_q <= code_q - 6'h01; // [R4]
    end
  end

  // stored copy and lock change only when the write completes
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stored_q <= UDW_CODE_MIN;
      lock_q <= 1'b0;
      pend_lock_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (state_q == ST_DESELECT)
        pend_lock_q <= is_hv ? lock_val : lock_q;
      if (state_q == ST_WRITE && tmr_done)
      begin
        stored_q <= code_q; // [R14]
        lock_q <= pend_lock_q; // [R14]
      end
    end
  end

  assign o_pins.cs_level = cs_q;
  assign o_pins.step_dir = step_q;
  assign o_busy = (state_q != ST_IDLE);
  assign o_write_busy = (state_q == ST_WRITE); // [R15]
  assign o_wiper_code = code_q;
  assign o_stored_code = stored_q;
  assign o_lock = lock_q;

endmodule : udw_host
`default_nettype wire

/* File: udw_dev_model.sv */
// Purpose: behavioural up/down wiper device on the far side of the host
// Assumes: pins only change on system clock edges
// Notes: o_viol counts chip select moves made while a write is running
`timescale 1ns/1ns
`default_nettype none
module udw_dev_model
  import udw_pkg::*;
#(
  parameter int WR_CYC = 20
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // pins from the host
  input wire udw_pins_s i_pins,
  // device state
  output logic [5:0] o_wiper,
  output logic [5:0] o_stored,
  output logic o_lock,
  output logic [7:0] o_viol
);
  udw_pins_s p_q;
  logic dir_q;
  logic nl_q;
  int wc_q;
  wire sel = i_pins.cs_level != UDW_CS_HIGH;
  wire hv_out = p_q.cs_level == UDW_CS_HV && !sel;
  wire rise = sel && i_pins.step_dir && !p_q.step_dir;
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      p_q <= '{UDW_CS_HIGH, 1'b0};
      {dir_q, nl_q, o_lock, o_wiper, o_stored, o_viol} <= '0;
      wc_q <= 0;
    end
    else
    begin
      p_q <= i_pins;
      if (wc_q != 0)
      begin
        // the pins are only watched for chip select moves until the write is over
        wc_q <= wc_q - 1;
        o_viol <= o_viol + 8'(i_pins.cs_level != p_q.cs_level);
        if (wc_q == 1)
          {o_stored, o_lock} <= {o_wiper, nl_q};
      end
      else
      begin
        if (sel && p_q.cs_level == UDW_CS_HIGH)
          dir_q <= i_pins.step_dir;
        if (rise && dir_q && o_wiper != 6'h3F)
          o_wiper <= o_wiper + 6'h01;
        if (rise && !dir_q && o_wiper != 6'h00)
          o_wiper <= o_wiper - 6'h01;
        if (hv_out)
          nl_q <= dir_q ^ i_pins.step_dir;
        else
          nl_q <= o_lock;
        if (hv_out || (!sel && p_q.cs_level == UDW_CS_LOW && i_pins.step_dir))
          wc_q <= WR_CYC;
      end
    end
  end
endmodule : udw_dev_model
`default_nettype wire

/* File: udw_host_props.sv */
// Purpose: port checker for the up/down wiper host
// Assumes: one clock domain
// Notes: write length counted in enabled cycles only
`timescale 1ns/1ns
`default_nettype none
module udw_host_chk
  import udw_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYC = 20,
  parameter int unsigned SETUP_CYC = 2
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // command port
  input wire logic i_cmd_valid,
  input wire udw_cmd_s i_cmd,
  input wire logic o_cmd_ready,
  // pins and status
  input wire udw_pins_s o_pins,
  input wire logic o_busy,
  input wire logic o_write_busy,
  input wire logic [UDW_CODE_W-1:0] o_wiper_code,
  input wire logic [UDW_CODE_W-1:0] o_stored_code,
  input wire logic o_lock
);
  int wc_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wc_q <= 0;
    else if (!o_write_busy)
      wc_q <= 0;
    else if (i_ce)
      wc_q <= wc_q + 1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_hv_exit_write: assert property (o_pins.cs_level == UDW_CS_HIGH && $past(o_pins.cs_level) == UDW_CS_HV
    |-> ##[0:8] o_write_busy) else $error("no write after high-voltage exit");
  // the timer runs down the full count, then one more enabled cycle to see it done
  a_write_time: assert property ($fell(o_write_busy) |-> wc_q == NV_WRITE_CYC + 1)
    else $error("write wait has wrong length");
  a_write_quiet: assert property (o_write_busy |-> o_pins.cs_level == UDW_CS_HIGH && !o_cmd_ready)
    else $error("pins moved during write");
  a_one_step: assert property ($changed(o_wiper_code) |-> 6'(o_wiper_code - $past(o_wiper_code)) inside {6'h01, 6'h3F})
    else $error("wiper moved more than one step");
  a_floor_clamp: assert property ($past(o_wiper_code) == 6'h00 |-> o_wiper_code != 6'h3F)
    else $error("wiper wrapped below zero");
  a_top_clamp: assert property ($past(o_wiper_code) == 6'h3F |-> o_wiper_code != 6'h00)
    else $error("wiper wrapped above top");
  a_step_select: assert property ($changed(o_wiper_code) |-> o_pins.step_dir && o_pins.cs_level != UDW_CS_HIGH)
    else $error("wiper moved without a selected rising edge");
  a_stored_late: assert property ($changed(o_stored_code) || $changed(o_lock) |-> $past(o_write_busy))
    else $error("stored copy changed outside a write");
  a_take_busy: assert property (i_cmd_valid && o_cmd_ready && i_ce |=> o_busy && !o_cmd_ready)
    else $error("taken command not busy");
endmodule : udw_host_chk
bind udw_host udw_host_chk #(.NV_WRITE_CYC(NV_WRITE_CYC), .SETUP_CYC(SETUP_CYC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_pins(o_pins), .o_busy(o_busy), .o_write_busy(o_write_busy),
  .o_wiper_code(o_wiper_code), .o_stored_code(o_stored_code), .o_lock(o_lock));
`default_nettype wire

/* File: udw_host_bench.sv */
// Purpose: self-checking bench for the up/down wiper host
// Assumes: short write and setup counts for simulation
// Notes: clock enable drops one cycle in eight to stretch every phase
`timescale 1ns/1ns
`default_nettype none
module udw_host_bench;
  import udw_pkg::*;
  localparam int NV = 20;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic i_cmd_valid = 1'b0;
  udw_cmd_s i_cmd = '0;
  logic o_cmd_ready, o_busy, o_write_busy, o_lock, m_l;
  udw_pins_s o_pins;
  logic [5:0] o_wiper_code, o_stored_code, m_w, m_s, e_w = 6'h00, e_s = 6'h00;
  logic [7:0] m_viol;
  logic e_l = 1'b0;
  logic [2:0] ce_q = 3'h0;
  logic [31:0] lf = 32'h97C7;
  int err_count = 0;
  int check_count = 0;
  udw_host #(.NV_WRITE_CYC(NV), .SETUP_CYC(2)) dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_pins(o_pins), .o_busy(o_busy),
    .o_write_busy(o_write_busy), .o_wiper_code(o_wiper_code), .o_stored_code(o_stored_code), .o_lock(o_lock));
  udw_dev_model #(.WR_CYC(NV)) u_dev (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_pins(o_pins),
    .o_wiper(m_w), .o_stored(m_s), .o_lock(m_l), .o_viol(m_viol));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
  begin
    ce_q <= ce_q + 3'h1;
    i_ce <= ce_q != 3'h6;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic void expect_of(input udw_op_e op, input logic [5:0] n);
    // a decrement that exits high always makes at least one rising edge
    int cnt = (n == 6'h00 && op inside {UDW_OP_DEC_STORE, UDW_OP_HV_DEC_LOCK}) ? 1 : int'(n);
    for (int k = 0; k < cnt; k++)
      if (op inside {UDW_OP_DEC, UDW_OP_DEC_STORE, UDW_OP_HV_DEC_UNLOCK, UDW_OP_HV_DEC_LOCK})
        e_w = (e_w == 6'h00) ? e_w : e_w - 6'h01;
      else if (!(op inside {UDW_OP_STORE, UDW_OP_HV_STORE_UNLOCK, UDW_OP_HV_STORE_LOCK}))
        e_w = (e_w == 6'h3F) ? e_w : e_w + 6'h01;
    if (!(op inside {UDW_OP_INC, UDW_OP_DEC}))
      e_s = e_w;
    if (op inside {UDW_OP_HV_INC_LOCK, UDW_OP_HV_DEC_LOCK, UDW_OP_HV_STORE_LOCK})
      e_l = 1'b1;
    else if (op inside {UDW_OP_HV_INC_UNLOCK, UDW_OP_HV_DEC_UNLOCK, UDW_OP_HV_STORE_UNLOCK})
      e_l = 1'b0;
  endfunction : expect_of
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [3:0] op, input logic [5:0] n);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{udw_op_e'(op), n};
    // held until an enabled edge finds the host ready
    do @(negedge i_sys_clk); while (!(o_cmd_ready === 1'b1 && i_ce === 1'b1) && ++k < 9000);
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    do @(negedge i_sys_clk); while (o_cmd_ready !== 1'b1 && ++k < 9000);
    if (k >= 9000)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, k, 9000);
    end
    expect_of(udw_op_e'(op), n);
    chk(o_wiper_code, e_w);
    chk(m_w, e_w);
    chk(o_stored_code, e_s);
    chk(m_s, e_s);
    chk({4'h0, o_lock, m_l}, {4'h0, e_l, e_l});
    chk(m_viol[5:0], 6'h00);
  endtask : run
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    chk({3'h0, o_pins.cs_level, o_pins.step_dir}, 6'h02);
    i_resetn <= 1'b1;
    run(4'h1, 6'h03);
    run(4'h6, 6'h3F);
    run(4'h0, 6'h05);
    for (int k = 0; k < 11; k++)
      run(k[3:0], 6'h02);
    repeat (30)
    begin
      lf = nx(lf);
      run(4'(lf[7:0] % 8'd11), {2'h0, lf[11:8]});
    end
    summarize;
  end
  initial
  begin
    #1000000;
    err_count++;
    summarize;
  end
endmodule : udw_host_bench
`default_nettype wire
